// ---- rtl/tmr_defs.svh ----
/*
 * Register offsets, field positions, reset values and timing counts for the
 * timer output and prescaler control block.
 * Assumes inclusion by bare name from design and test files.
 */
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

// ****************************************************************
// Register word indices (printed offsets are not all word aligned,
// so each is an index and the byte address is four times it)
// ****************************************************************
`define IDX_PORT2_DIR 16'hFF22
`define IDX_PRESCALER 16'hFF61
`define IDX_OUT_CTRL 16'hFF63
`define IDX_PORT2_ANA 16'hFF84
`define IDX_MODE_CTRL 16'hFF60
`define IDX_STATUS 16'hFF70
`define ADDR_W 18

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_PORT2_DIR 8'hFF
`define RST_PRESCALER 8'h00
`define RST_OUT_CTRL 8'h00
`define RST_PORT2_ANA 8'h00
`define RST_MODE_CTRL 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define OC_PIN_EN 0
`define OC_INV_ZERO 1
`define OC_LVL_CLR 2
`define OC_LVL_SET 3
`define OC_INV_ONE 4
`define OC_OS_EN 5
`define OC_OS_TRIG 6
`define PS_CLK_LO 0
`define PS_EDGE_A_LO 4
`define PS_EDGE_B_LO 6
`define MC_MODE_LO 1
`define OC_RD_MASK 8'h33
`define PS_RD_MASK 8'hF3
`define MC_RD_MASK 8'h0E
`define PA_RD_MASK 8'h0F

// ****************************************************************
// Prescaler divide counts
// ****************************************************************
`define DIV4_LAST 8'h03
`define DIV256_LAST 8'hFF

`endif

// ---- rtl/tmr_pkg.sv ----
/*
 * Types for the timer output and prescaler control block.
 * Assumes tmr_defs.svh holds all numeric constants.
 */
package tmr_pkg;

  typedef enum logic [1:0] {
    EDGE_FALL,
    EDGE_RISE,
    EDGE_BAD,
    EDGE_BOTH
  } edge_sel_t;

  typedef enum logic [1:0] {
    CLK_DIV1,
    CLK_DIV4,
    CLK_DIV256,
    CLK_EDGE_A
  } clk_sel_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [17:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avm_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
    logic [1:0] response;
  } avm_rsp_t;

endpackage

// ---- rtl/edge_filter.sv ----
/*
 * Input synchroniser, two-sample noise filter and valid-edge detector.
 * Assumes i_pin is asynchronous; i_sample marks filter sampling cycles.
 */
`include "tmr_defs.svh"

module edge_filter
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_sample,
  input wire logic i_run,
  input wire edge_sel_t i_edge,
  // Pin and result
  input wire logic i_pin,
  output logic o_edge
);

  logic sync1_r;
  logic sync2_r;
  logic samp_r;
  logic level_r;
  logic prev_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
    end
  end

  // Level accepted only when two consecutive samples agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      samp_r <= 1'b0;
      level_r <= 1'b0;
    end else if (i_sample) begin
      samp_r <= sync2_r;
      if (samp_r == sync2_r) begin
        level_r <= sync2_r;
      end
    end
  end

  // Last held level freezes while stopped, low after reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_r <= 1'b0;
    end else if (i_run) begin
      prev_r <= level_r;
    end
  end

  // Edge code decode
  always_comb begin
    o_edge = 1'b0;
    if (i_run && (prev_r != level_r)) begin
      unique case (i_edge)
        EDGE_FALL: o_edge = !level_r;
        EDGE_RISE: o_edge = level_r;
        EDGE_BAD: o_edge = 1'b0;
        EDGE_BOTH: o_edge = 1'b1;
      endcase
    end
  end

endmodule

// ---- rtl/count_prescaler.sv ----
/*
 * Count clock selection: divide by 1, 4, 256 or input A valid edges.
 * Assumes i_edge_a is a one-cycle pulse on the same clock.
 */
`include "tmr_defs.svh"

module count_prescaler
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire clk_sel_t i_sel,
  input wire logic i_edge_a,
  // Count enable pulse
  output logic o_tick
);

  logic [7:0] div_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 8'h00;
    end else if (!i_run) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Count clock selection
  always_comb begin
    unique case (i_sel)
      CLK_DIV1: o_tick = i_run;
      CLK_DIV4: o_tick = i_run && (div_r[1:0] == `DIV4_LAST);
      CLK_DIV256: o_tick = i_run && (div_r == `DIV256_LAST);
      CLK_EDGE_A: o_tick = i_run && i_edge_a;
    endcase
  end

endmodule

// ---- rtl/timer_output_prescaler_control.sv ----
/*
 * Timer output control, prescaler and edge selection, shared pin setup,
 * with a small counter core so compare matches drive the output flip-flop.
 * Assumes an Avalon-MM master on i_clk (20 MHz) and asynchronous pins.
 */
`include "tmr_defs.svh"

module timer_output_prescaler_control
  import tmr_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire avm_req_t i_avm,
  output avm_rsp_t o_avm,
  // Compare values from the counter core
  input wire logic [CNT_W-1:0] i_cmp_zero,
  input wire logic [CNT_W-1:0] i_cmp_one,
  // Port 2 pins
  input wire logic i_event_input_a,
  input wire logic i_port2_pin1,
  output logic o_port2_pin1,
  output logic o_port2_pin1_oe,
  output logic o_main_counter_nz
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] port2_direction_r;
  logic [7:0] prescaler_edge_select_r;
  logic [7:0] timer_output_control_r;
  logic [7:0] port2_analog_select_r;
  logic [7:0] timer_mode_control_r;
  logic [CNT_W-1:0] main_counter_r;
  logic out_ff_r;
  logic os_active_r;
  logic os_pend_r;
  logic [31:0] rdata_r;
  logic [1:0] resp_r;
  logic ack_r;

  logic run;
  logic tick;
  logic tick_a_filt;
  logic edge_a;
  logic edge_b;
  logic sample_a;
  logic sample_b;
  logic [2:0] mode;
  logic match_zero;
  logic match_one;
  logic overflow;
  logic clear_start;
  logic acc;
  logic wr_hit;
  logic [7:0] wbyte;
  logic lvl_set;
  logic lvl_clr;
  logic os_trig;
  logic pin1_as_input;
  clk_sel_t clk_sel;

  // ****************************************************************
  // Bus helpers
  // ****************************************************************
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic known(input logic [17:0] a);
    known = hit(a, `IDX_PORT2_DIR) || hit(a, `IDX_PRESCALER) ||
            hit(a, `IDX_OUT_CTRL) || hit(a, `IDX_PORT2_ANA) ||
            hit(a, `IDX_MODE_CTRL) || hit(a, `IDX_STATUS);
  endfunction

  // One wait cycle on every access, answered on the following edge;
  // a write lands only at the edge where waitrequest is seen low
  assign acc = (i_avm.read || i_avm.write) && !ack_r;
  assign wr_hit = i_avm.write && ack_r && i_avm.byteenable[0];
  assign wbyte = i_avm.writedata[7:0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Writes land whatever the timer state; software keeps it stopped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      port2_direction_r <= `RST_PORT2_DIR;
      prescaler_edge_select_r <= `RST_PRESCALER;
      timer_output_control_r <= `RST_OUT_CTRL;
      port2_analog_select_r <= `RST_PORT2_ANA;
      timer_mode_control_r <= `RST_MODE_CTRL;
    end else if (wr_hit) begin
      if (hit(i_avm.address, `IDX_PORT2_DIR)) begin
        port2_direction_r <= wbyte;
      end
      if (hit(i_avm.address, `IDX_PRESCALER)) begin
        prescaler_edge_select_r <= wbyte & `PS_RD_MASK;
      end
      // Level and trigger bits are strobes, never stored
      if (hit(i_avm.address, `IDX_OUT_CTRL)) begin
        timer_output_control_r <= wbyte & `OC_RD_MASK;
      end
      if (hit(i_avm.address, `IDX_PORT2_ANA)) begin
        port2_analog_select_r <= wbyte & `PA_RD_MASK;
      end
      if (hit(i_avm.address, `IDX_MODE_CTRL)) begin
        timer_mode_control_r <= wbyte & `MC_RD_MASK;
      end
    end
  end

  assign lvl_set = wr_hit && hit(i_avm.address, `IDX_OUT_CTRL) &&
                   wbyte[`OC_LVL_SET];
  assign lvl_clr = wr_hit && hit(i_avm.address, `IDX_OUT_CTRL) &&
                   wbyte[`OC_LVL_CLR];
  // Trigger is a write strobe: nothing to clear, always reads 0
  assign os_trig = wr_hit && hit(i_avm.address, `IDX_OUT_CTRL) &&
                   wbyte[`OC_OS_TRIG];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
      resp_r <= 2'b00;
    end else if (acc && i_avm.read) begin
      rdata_r <= 32'h0000_0000;
      resp_r <= known(i_avm.address) ? 2'b00 : 2'b10;
      if (hit(i_avm.address, `IDX_PORT2_DIR)) begin
        rdata_r[7:0] <= port2_direction_r;
      end
      if (hit(i_avm.address, `IDX_PRESCALER)) begin
        rdata_r[7:0] <= prescaler_edge_select_r;
      end
      if (hit(i_avm.address, `IDX_OUT_CTRL)) begin
        rdata_r[7:0] <= timer_output_control_r;
      end
      if (hit(i_avm.address, `IDX_PORT2_ANA)) begin
        rdata_r[7:0] <= port2_analog_select_r;
      end
      if (hit(i_avm.address, `IDX_MODE_CTRL)) begin
        rdata_r[7:0] <= timer_mode_control_r;
      end
      if (hit(i_avm.address, `IDX_STATUS)) begin
        rdata_r[CNT_W-1:0] <= main_counter_r;
        rdata_r[CNT_W] <= out_ff_r;
        rdata_r[CNT_W+1] <= os_active_r;
      end
    end else if (acc && i_avm.write) begin
      resp_r <= known(i_avm.address) ? 2'b00 : 2'b10;
    end
  end

  always_comb begin
    o_avm.readdata = rdata_r;
    o_avm.response = resp_r;
    o_avm.waitrequest = (i_avm.read || i_avm.write) && !ack_r;
  end

  // ****************************************************************
  // Mode, prescaler and input edges
  // ****************************************************************
  assign mode = timer_mode_control_r[`MC_MODE_LO +: 3];
  // Any nonzero upper pair runs the counter
  assign run = (mode[2:1] != 2'b00);
  assign clk_sel = clk_sel_t'(prescaler_edge_select_r[`PS_CLK_LO +: 2]);

  // Filter on peripheral clock when input A is the count clock, else on
  // the count clock
  assign sample_a = (clk_sel == CLK_EDGE_A) ? 1'b1 : tick;
  assign sample_b = tick;

  edge_filter u_filt_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sample(sample_a),
    .i_run(run),
    .i_edge(edge_sel_t'(prescaler_edge_select_r[`PS_EDGE_A_LO +: 2])),
    .i_pin(i_event_input_a),
    .o_edge(edge_a)
  );

  // Pin 1 input path is only live when configured as an input
  assign pin1_as_input = port2_direction_r[1] && !port2_analog_select_r[1];

  edge_filter u_filt_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sample(sample_b),
    .i_run(run && pin1_as_input),
    .i_edge(edge_sel_t'(prescaler_edge_select_r[`PS_EDGE_B_LO +: 2])),
    .i_pin(i_port2_pin1),
    .o_edge(edge_b)
  );

  assign tick_a_filt = edge_a;

  count_prescaler u_presc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(run),
    .i_sel(clk_sel),
    .i_edge_a(tick_a_filt),
    .o_tick(tick)
  );

  // ****************************************************************
  // Counter
  // ****************************************************************
  assign match_zero = run && tick && (main_counter_r == i_cmp_zero);
  assign match_one = run && tick && (main_counter_r == i_cmp_one);
  assign overflow = run && tick && (main_counter_r == {CNT_W{1'b1}});
  assign clear_start = (mode[2:1] == 2'b10) && edge_a &&
                       (clk_sel != CLK_EDGE_A);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      main_counter_r <= '0;
    end else if (!run) begin
      main_counter_r <= '0;
    end else if (clear_start) begin
      main_counter_r <= '0;
    end else if (tick) begin
      if ((mode[2:1] == 2'b11) && match_zero) begin
        main_counter_r <= '0;
      end else begin
        main_counter_r <= main_counter_r + 1'b1;
      end
    end
  end

  assign o_main_counter_nz = (main_counter_r != '0);

  // ****************************************************************
  // One-shot sequencing
  // ****************************************************************
  // Armed by trigger, or by input A edge in clear-start mode; rises on
  // match one, falls on match zero. Only free and input-A modes end it,
  // because match-zero clearing never overflows
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      os_pend_r <= 1'b0;
      os_active_r <= 1'b0;
    end else if (!timer_output_control_r[`OC_OS_EN] ||
                 (mode[2:1] == 2'b11) || !run) begin
      os_pend_r <= 1'b0;
      os_active_r <= 1'b0;
    end else if (os_trig || clear_start) begin
      os_pend_r <= 1'b1;
      os_active_r <= 1'b0;
    end else if (os_pend_r && match_one) begin
      os_pend_r <= 1'b0;
      os_active_r <= 1'b1;
    end else if (os_active_r && match_zero) begin
      os_active_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Output flip-flop
  // ****************************************************************
  // Level bits win over matches; 11 is prohibited and acts like 00, so matches still apply
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_ff_r <= 1'b0;
    end else if (lvl_set != lvl_clr) begin
      out_ff_r <= lvl_set;
    end else if (timer_output_control_r[`OC_OS_EN]) begin
      if (os_pend_r && match_one) begin
        out_ff_r <= 1'b1;
      end else if (os_active_r && match_zero) begin
        out_ff_r <= 1'b0;
      end
    end else if ((match_one && timer_output_control_r[`OC_INV_ONE]) ^
                 (match_zero && timer_output_control_r[`OC_INV_ZERO])) begin
      out_ff_r <= !out_ff_r;
    end
  end

  // ****************************************************************
  // Shared pin 1
  // ****************************************************************
  // Driven only in output mode, port function; disabled output is low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port2_pin1 <= 1'b0;
      o_port2_pin1_oe <= 1'b0;
    end else begin
      o_port2_pin1 <= timer_output_control_r[`OC_PIN_EN] && out_ff_r;
      o_port2_pin1_oe <= !port2_direction_r[1] &&
                         !port2_analog_select_r[1];
    end
  end

  logic unused_edge_b;
  assign unused_edge_b = edge_b && overflow;

endmodule

// ---- test/tmr_ctl_props.sv ----
/*
 * Checker for the timer output and prescaler control block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`include "tmr_defs.svh"

module tmr_ctl_props
  import tmr_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire avm_req_t i_avm,
  input wire avm_rsp_t o_avm,
  // Compare values
  input wire logic [CNT_W-1:0] i_cmp_zero,
  input wire logic [CNT_W-1:0] i_cmp_one,
  // Pins
  input wire logic i_event_input_a,
  input wire logic i_port2_pin1,
  input wire logic o_port2_pin1,
  input wire logic o_port2_pin1_oe,
  input wire logic o_main_counter_nz
);
  // ****************************************
  // Register shadows
  // ****************************************
  logic acc, hit, wr_ok, oe_r;
  logic [15:0] idx;
  logic [7:0] oc_r, ps_r, dir_r, ana_r, mode_r, exp_rd;

  assign idx = i_avm.address[17:2];
  assign acc = (i_avm.read | i_avm.write) & ~o_avm.waitrequest;
  assign hit = idx inside {`IDX_PORT2_DIR, `IDX_PRESCALER, `IDX_OUT_CTRL,
    `IDX_PORT2_ANA, `IDX_MODE_CTRL};
  assign wr_ok = acc & i_avm.write & i_avm.byteenable[0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oc_r <= `RST_OUT_CTRL;
      ps_r <= `RST_PRESCALER;
      dir_r <= `RST_PORT2_DIR;
      ana_r <= `RST_PORT2_ANA;
      mode_r <= `RST_MODE_CTRL;
      oe_r <= 1'b0;
    end else begin
      oe_r <= ~dir_r[1] & ~ana_r[1];
      if (wr_ok) begin
        case (idx)
          `IDX_OUT_CTRL: oc_r <= i_avm.writedata[7:0];
          `IDX_PRESCALER: ps_r <= i_avm.writedata[7:0];
          `IDX_PORT2_DIR: dir_r <= i_avm.writedata[7:0];
          `IDX_PORT2_ANA: ana_r <= i_avm.writedata[7:0];
          `IDX_MODE_CTRL: mode_r <= i_avm.writedata[7:0];
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    case (idx)
      `IDX_PORT2_DIR: exp_rd = dir_r;
      `IDX_PRESCALER: exp_rd = ps_r & `PS_RD_MASK;
      `IDX_OUT_CTRL: exp_rd = oc_r & `OC_RD_MASK;
      `IDX_PORT2_ANA: exp_rd = ana_r & `PA_RD_MASK;
      default: exp_rd = mode_r & `MC_RD_MASK;
    endcase
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_lvl_wr(logic [1:0] v);
    wr_ok && idx == `IDX_OUT_CTRL && i_avm.writedata[3:2] == v &&
      i_avm.writedata[0];
  endsequence

  chk_wait_ack: assert property (
    (i_avm.read | i_avm.write) && o_avm.waitrequest |=> !o_avm.waitrequest)
    else $error("waitrequest held past one cycle");
  chk_wait_idle: assert property (
    !(i_avm.read | i_avm.write) |-> !o_avm.waitrequest)
    else $error("waitrequest without a request");
  chk_resp_code: assert property (
    acc |-> o_avm.response == ((hit || idx == `IDX_STATUS) ? 2'b00 : 2'b10))
    else $error("wrong response code");
  chk_reg_readback: assert property (
    acc && i_avm.read && hit |-> o_avm.readdata == {24'h0, exp_rd})
    else $error("register read value wrong");
  chk_level_set: assert property (
    s_lvl_wr(2'b10) |=> ##1 o_port2_pin1)
    else $error("level set did not raise pin");
  chk_level_clear: assert property (
    s_lvl_wr(2'b01) |=> ##1 !o_port2_pin1)
    else $error("level clear did not lower pin");
  chk_pin_off_low: assert property (
    !oc_r[0] && !$past(oc_r[0]) |-> !o_port2_pin1)
    else $error("disabled output not low");
  chk_oe_map: assert property (
    o_port2_pin1_oe == oe_r)
    else $error("pin drive enable wrong");
  chk_stop_clear: assert property (
    mode_r[3:1] == 3'b000 && $past(mode_r[3:1]) == 3'b000 &&
      $past(mode_r[3:1], 2) == 3'b000 |-> !o_main_counter_nz)
    else $error("counter not cleared when stopped");
endmodule

bind timer_output_prescaler_control tmr_ctl_props #(.CNT_W(CNT_W)) u_props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_avm(i_avm),
  .o_avm(o_avm),
  .i_cmp_zero(i_cmp_zero),
  .i_cmp_one(i_cmp_one),
  .i_event_input_a(i_event_input_a),
  .i_port2_pin1(i_port2_pin1),
  .o_port2_pin1(o_port2_pin1),
  .o_port2_pin1_oe(o_port2_pin1_oe),
  .o_main_counter_nz(o_main_counter_nz)
);

// ---- test/pin_partner.sv ----
/*
 * Pin-side model: event source on input A and the shared pin 1 wire.
 * Assumes its tasks are called just after a rising clock edge.
 */
module pin_partner (
  // Clock
  input wire logic i_clk,
  // Shared pin as driven by the block
  input wire logic i_oe,
  input wire logic i_drv,
  // Levels seen by the block
  output logic o_event_input_a,
  output logic o_port2_pin1
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Pin levels
  // ****************************************
  logic ext_b;

  initial begin
    o_event_input_a = 1'b0;
    ext_b = 1'b0;
  end

  // The outside source backs off while the block drives the pin
  assign o_port2_pin1 = i_oe ? i_drv : ext_b;

  // Width below two clocks only when a scenario wants a glitch
  task pulse_a(input int hi, input int lo);
    o_event_input_a <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_event_input_a <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask

  task set_a(input logic v);
    o_event_input_a <= v;
    @(posedge i_clk);
  endtask
endmodule

// ---- test/timer_output_prescaler_control_tb_top.sv ----
/*
 * Testbench for the timer output and prescaler control block.
 * Assumes the checker is bound in and pin_partner models the pins.
 */
`include "tmr_defs.svh"

module timer_output_prescaler_control_tb_top
  import tmr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic i_clk, i_rst, pin_a, pin1_in, pin1_out, pin1_oe, nz;
  avm_req_t req;
  avm_rsp_t rsp;
  logic [15:0] cmp0, cmp1;
  logic [31:0] rd, r;
  logic [1:0] rs;
  int n_fail = 0;
  int total_checks = 0;
  int k;
  // ps, output control, trigger, expected pin edges
  // Bits 15:12 add the match-zero clear mode to the mode write
  localparam logic [31:0] ROWS [11] = '{32'h0001_0000, 32'h0003_0001,
    32'h0011_0001, 32'h0013_0002, 32'h0113_0001, 32'h0213_0000,
    32'h0021_0000, 32'h0021_0102, 32'h0003_C003, 32'h0013_C006,
    32'h0021_C100};
  // ps, expected count after five pulses and a glitch
  localparam logic [15:0] EXT [3] = '{16'h1305, 16'h0305, 16'h330A};

  timer_output_prescaler_control #(.CNT_W(16)) dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_avm(req),
    .o_avm(rsp),
    .i_cmp_zero(cmp0),
    .i_cmp_one(cmp1),
    .i_event_input_a(pin_a),
    .i_port2_pin1(pin1_in),
    .o_port2_pin1(pin1_out),
    .o_port2_pin1_oe(pin1_oe),
    .o_main_counter_nz(nz)
  );

  pin_partner u_pins (
    .i_clk(i_clk),
    .i_oe(pin1_oe),
    .i_drv(pin1_out),
    .o_event_input_a(pin_a),
    .o_port2_pin1(pin1_in)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Request held until waitrequest is sampled low at a rising edge; the
  // watchdog is the only limit on the wait
  task bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
      input logic [3:0] be);
    req.address <= {idx, 2'b00};
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= {24'h0, d};
    req.byteenable <= be;
    @(posedge i_clk);
    while (rsp.waitrequest !== 1'b0) begin
      @(posedge i_clk);
    end
    rd = rsp.readdata;
    rs = rsp.response;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge i_clk);
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task rdchk(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    check(rd, exp);
  endtask

  task pin_chk(input logic oe, input logic lvl);
    @(negedge i_clk);
    check(pin1_oe, oe);
    check(pin1_out, lvl);
    @(posedge i_clk);
  endtask

  task count_edges(input int cyc);
    logic prev;
    @(negedge i_clk);
    prev = pin1_out;
    k = 0;
    repeat (cyc) begin
      @(negedge i_clk);
      if (pin1_out !== prev)
        k++;
      prev = pin1_out;
    end
    @(posedge i_clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    i_rst = 1'b1;
    req = '0;
    cmp0 = 16'h0020;
    cmp1 = 16'h0010;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdchk(`IDX_PORT2_DIR, 32'hFF);
    rdchk(`IDX_PRESCALER, 32'h00);
    rdchk(`IDX_OUT_CTRL, 32'h00);
    rdchk(`IDX_PORT2_ANA, 32'h00);
    bus(1'b0, 16'hFF00, 8'h00, 4'h1);
    check(rs, 2'b10);
    $display("test reset values done");
    wr(`IDX_OUT_CTRL, 8'hF7);
    rdchk(`IDX_OUT_CTRL, 32'h33);
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        r = c;
        wr(`IDX_PRESCALER, {r[1:0], r[1:0], 2'b11, r[1:0]});
        rdchk(`IDX_PRESCALER, {24'h0, r[1:0], r[1:0], 2'b00, r[1:0]});
      end
    end
    bus(1'b1, `IDX_PRESCALER, 8'h00, 4'h0);
    rdchk(`IDX_PRESCALER, 32'hF3);
    $display("test readback done");
    wr(`IDX_PORT2_DIR, 8'hFD);
    wr(`IDX_OUT_CTRL, 8'h09);
    pin_chk(1'b1, 1'b1);
    wr(`IDX_OUT_CTRL, 8'h05);
    pin_chk(1'b1, 1'b0);
    wr(`IDX_OUT_CTRL, 8'h08);
    pin_chk(1'b1, 1'b0);
    wr(`IDX_OUT_CTRL, 8'h01);
    pin_chk(1'b1, 1'b1);
    wr(`IDX_PORT2_ANA, 8'h02);
    pin_chk(1'b0, 1'b1);
    wr(`IDX_PORT2_ANA, 8'h00);
    wr(`IDX_PORT2_DIR, 8'hFF);
    pin_chk(1'b0, 1'b1);
    $display("test pin control done");
    for (int i = 0; i < 11; i++) begin
      r = ROWS[i];
      wr(`IDX_MODE_CTRL, 8'h00);
      wr(`IDX_OUT_CTRL, 8'h05);
      check(nz, 1'b0);
      wr(`IDX_PRESCALER, r[31:24]);
      wr(`IDX_OUT_CTRL, r[23:16]);
      wr(`IDX_MODE_CTRL, 8'h04 | {4'h0, r[15:12]});
      if (r[8])
        wr(`IDX_OUT_CTRL, r[23:16] | 8'h40);
      count_edges(100);
      check(k, {24'h0, r[7:0]});
      // Divide by 256 has not ticked yet after about a hundred cycles
      check(nz, {31'h0, !r[25]});
    end
    $display("test output toggles done");
    for (int j = 0; j < 3; j++) begin
      wr(`IDX_MODE_CTRL, 8'h00);
      wr(`IDX_PRESCALER, EXT[j][15:8]);
      wr(`IDX_MODE_CTRL, 8'h04);
      repeat (5) u_pins.pulse_a(3, 3);
      u_pins.pulse_a(1, 6);
      bus(1'b0, `IDX_STATUS, 8'h00, 4'h1);
      check(rd[15:0], {8'h00, EXT[j][7:0]});
    end
    // Clear and start on a rising input A edge restarts the count
    wr(`IDX_MODE_CTRL, 8'h00);
    wr(`IDX_PRESCALER, 8'h10);
    wr(`IDX_MODE_CTRL, 8'h08);
    u_pins.pulse_a(3, 3);
    bus(1'b0, `IDX_STATUS, 8'h00, 4'h1);
    check(rd[15:0], 16'h0001);
    wr(`IDX_MODE_CTRL, 8'h00);
    u_pins.set_a(1'b1);
    wr(`IDX_PRESCALER, 8'h13);
    wr(`IDX_MODE_CTRL, 8'h04);
    repeat (8) @(posedge i_clk);
    bus(1'b0, `IDX_STATUS, 8'h00, 4'h1);
    check(rd[15:0], 16'h0001);
    $display("test external clock done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    $display("watchdog expired");
    summarize();
  end
endmodule
